/* hw/arr_pkg.sv */
// Shared constants and types for the converter run and auxiliary round-robin block
package arr_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned AUX_SLOT_US     = 8;
    localparam int unsigned AUX_SLOT_CYC    = (AUX_SLOT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [8:0]  AUX_SLOT_LAST   = 9'(AUX_SLOT_CYC - 1);
    localparam logic [4:0]  AUX_SLOT_MAX    = 5'h17;
    localparam logic [7:0]  MAIN_RR_LAST    = 8'h3f;
    localparam logic [7:0]  BURST_LAST      = 8'h07;
    localparam logic [7:0]  READY_LAST      = 8'h07;
    localparam logic [7:0]  RR_CNT_SAT      = 8'hff;
    localparam int unsigned SETTLE_CYC_DEF  = 256;

    // Run modes
    localparam logic [1:0]  MODE_STOP       = 2'h0;
    localparam logic [1:0]  MODE_BURST      = 2'h1;
    localparam logic [1:0]  MODE_CONT       = 2'h2;

    // Auxiliary slot map
    localparam logic [4:0]  SLOT_DIETEMP    = 5'h00;
    localparam logic [4:0]  SLOT_BAL        = 5'h01;
    localparam logic [4:0]  SLOT_GPIO       = 5'h0d;
    localparam int unsigned N_RESULTS       = 14;
    localparam logic [15:0] RESULT_DEFAULT  = 16'h8000;
    localparam logic [4:0]  BAL_SEL_LOOP    = 5'h00;
    localparam logic [4:0]  BAL_SEL_SHUNT   = 5'h01;

    // Register offsets
    localparam logic [11:0] REG_CTRL        = 12'h000;
    localparam logic [11:0] REG_CFG         = 12'h004;
    localparam logic [11:0] REG_STAT        = 12'h008;
    localparam logic [11:0] REG_LSHIFT      = 12'h00c;
    localparam logic [11:0] REG_RES_BASE    = 12'h040;

    // Field positions and reset values
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_GO_BIT     = 2;
    localparam int unsigned CTRL_AUX_EN_BIT = 3;
    localparam int unsigned CFG_NCELL_LSB   = 0;
    localparam int unsigned CFG_BSEL_LSB    = 8;
    localparam logic [4:0]  NCELL_RESET     = 5'h10;
    localparam logic [4:0]  NCELL_MAX       = 5'h10;

    // Bus answers
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Main sequencer states
    typedef enum logic [2:0] {
        MST_IDLE   = 3'h1,
        MST_RUN    = 3'h2,
        MST_FROZEN = 3'h4
    } arr_mst_e;

    typedef struct packed {
        logic       run;
        logic       frozen;
        logic       ready;
        logic       cont;
        logic       cycle_done;
        logic [7:0] rr_cnt;
    } arr_main_stat_s;

    typedef struct packed {
        logic       valid;
        logic       hi;
        logic [3:0] idx;
    } arr_dec_s;

endpackage

/* hw/arr_main_seq.sv */
// Main converter run-mode sequencer with freeze and resume
`timescale 1ns/1ps
`default_nettype none
module arr_main_seq (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Control
    input  wire logic                    go,
    input  wire logic [1:0]              mode,
    input  wire logic                    dev_active,
    // Status
    output arr_pkg::arr_main_stat_s      stat
);

    arr_pkg::arr_mst_e state_r;
    logic [1:0]        mode_r;
    logic [7:0]        tmr_r;
    logic [7:0]        rr_cnt_r;
    logic              ready_r;
    logic              done_r;
    logic              running;
    logic              cycle_end;

    assign running   = (state_r == arr_pkg::MST_RUN);
    assign cycle_end = running && (tmr_r == arr_pkg::MAIN_RR_LAST);

    // Go is ignored outside the active state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= arr_pkg::MST_IDLE;
        end else if (go && dev_active) begin
            state_r <= (mode == arr_pkg::MODE_STOP) ? arr_pkg::MST_IDLE : arr_pkg::MST_RUN;
        end else begin
            case (state_r)
                arr_pkg::MST_IDLE: begin
                    state_r <= arr_pkg::MST_IDLE;
                end
                arr_pkg::MST_RUN: begin
                    if (!dev_active) begin
                        state_r <= arr_pkg::MST_FROZEN;
                    end else if (cycle_end && mode_r == arr_pkg::MODE_BURST &&
                                 rr_cnt_r == arr_pkg::BURST_LAST) begin
                        state_r <= arr_pkg::MST_IDLE;
                    end
                end
                arr_pkg::MST_FROZEN: begin
                    if (dev_active) begin
                        state_r <= arr_pkg::MST_RUN;
                    end
                end
                default: begin
                    state_r <= arr_pkg::MST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= arr_pkg::MODE_STOP;
        end else if (go && dev_active) begin
            mode_r <= mode;
        end
    end

    // Counters hold while frozen so the sequence picks up where it left
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_r    <= 8'h00;
            rr_cnt_r <= 8'h00;
        end else if (go && dev_active) begin
            tmr_r    <= 8'h00;
            rr_cnt_r <= 8'h00;
        end else if (cycle_end) begin
            tmr_r    <= 8'h00;
            rr_cnt_r <= (rr_cnt_r == arr_pkg::RR_CNT_SAT) ? rr_cnt_r : rr_cnt_r + 8'h01;
        end else if (running) begin
            tmr_r    <= tmr_r + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            done_r <= cycle_end;
            if (go && dev_active) begin
                ready_r <= 1'b0;
            end else if (cycle_end && rr_cnt_r >= arr_pkg::READY_LAST) begin
                ready_r <= 1'b1;
            end
        end
    end

    assign stat.run        = running;
    assign stat.frozen     = (state_r == arr_pkg::MST_FROZEN);
    assign stat.ready      = ready_r;
    assign stat.cont       = (mode_r == arr_pkg::MODE_CONT);
    assign stat.cycle_done = done_r;
    assign stat.rr_cnt     = rr_cnt_r;

endmodule
`default_nettype wire

/* hw/arr_aux_seq.sv */
// Auxiliary converter slot timer and round-robin slot counter
`timescale 1ns/1ps
`default_nettype none
module arr_aux_seq (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       en,
    // Slot position
    output logic [4:0]      slot,
    output logic            slot_done
);

    logic [8:0] tmr_r;
    logic       last;

    assign last      = (tmr_r == arr_pkg::AUX_SLOT_LAST);
    // Flagged while slot still names the finished slot, so its result lands in its own pair
    assign slot_done = last;

    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            tmr_r     <= 9'h000;
            slot      <= 5'h00;
        end else begin
            if (last) begin
                tmr_r <= 9'h000;
                slot  <= (slot == arr_pkg::AUX_SLOT_MAX) ? 5'h00 : slot + 5'h01;
            end else begin
                tmr_r <= tmr_r + 9'h001;
            end
        end
    end

endmodule
`default_nettype wire

/* hw/arr_top.sv */
// Top of the converter run and auxiliary round-robin block with its register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Burst mode runs eight main cycles, then stops by itself.
// - Filtered results are flagged valid only in continuous mode.
// - Continuous mode runs until stop code written and go issued.
// - Entering active enables level shifters for the configured cell count.
// - Main converter runs only when active; sleep freezes it, keeping state.
// - Back in active, main converter resumes from its frozen state.
// - Auxiliary converter walks 24 slots in fixed round-robin order.
// - Each auxiliary slot lasts 8 us, a full cycle 192 us.
// - Slots: die temperature, balance, eleven misc, GPIO, spares.
// - Every auxiliary result is a 16-bit two's complement value.
// - Each result splits into an upper and a lower byte register.
// - Auxiliary enable loads every result pair with 0x8000.
// - A slot's result is written when its conversion completes.
// - Reading an upper byte freezes its lower byte until read.
// - Balance result updates only while locked to one channel.
// - Die temperature code zero means zero degrees, signed.
// - Ready flag sets after eight completed main cycles.
module arr_top #(
    parameter int unsigned SETTLE_CYC = arr_pkg::SETTLE_CYC_DEF
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Power state
    input  wire logic        dev_active,
    // Analog front end
    input  wire logic [15:0] aux_conv_data,
    output logic [4:0]       aux_mux_slot,
    output logic             aux_slot_done,
    output logic [15:0]      level_shift_en,
    output logic             main_running,
    output logic             main_cycle_strobe
);

    arr_pkg::arr_main_stat_s mstat;
    arr_pkg::arr_dec_s       rd_dec;

    // Register state
    logic [1:0]  mode_r;
    logic        go_r;
    logic        aux_en_r;
    logic        aux_en_d_r;
    logic [4:0]  num_cell_r;
    logic [4:0]  bal_sel_r;
    logic        active_d_r;
    logic [15:0] ls_en_r;
    logic [31:0] settle_r;

    // Bus state
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic        wr_ok;
    logic        rd_fire;
    logic [31:0] rd_data_c;
    logic        rd_ok_c;

    // Result storage
    logic [7:0]  res_hi_r [arr_pkg::N_RESULTS];
    logic [7:0]  res_lo_r [arr_pkg::N_RESULTS];
    logic        lo_hold_r [arr_pkg::N_RESULTS];
    logic [4:0]  slot;
    logic        slot_done;
    logic        aux_start;
    logic        bal_locked;
    logic        filt_valid;

    function automatic arr_pkg::arr_dec_s res_decode(input logic [11:0] a);
        arr_pkg::arr_dec_s d;
        logic [11:0]       off;
        off     = a - arr_pkg::REG_RES_BASE;
        d.valid = (a >= arr_pkg::REG_RES_BASE) && (off[11:3] < 9'(arr_pkg::N_RESULTS));
        d.hi    = ~off[2];
        d.idx   = off[6:3];
        return d;
    endfunction

    arr_main_seq u_main (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .go         (go_r),
        .mode       (mode_r),
        .dev_active (dev_active),
        .stat       (mstat)
    );

    arr_aux_seq u_aux (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .en        (aux_en_r),
        .slot      (slot),
        .slot_done (slot_done)
    );

    // Write channel: address and data taken in either order
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ok   = ({awaddr_r[11:2], 2'b00} == arr_pkg::REG_CTRL) ||
                     ({awaddr_r[11:2], 2'b00} == arr_pkg::REG_CFG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= arr_pkg::RESP_OKAY;
            awaddr_r      <= 12'h000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_r      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? arr_pkg::RESP_OKAY : arr_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Go is a one-cycle pulse; mode lands in the same cycle so the sequencer sees both together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r   <= arr_pkg::MODE_STOP;
            go_r     <= 1'b0;
            aux_en_r <= 1'b0;
        end else begin
            go_r <= 1'b0;
            if (wr_fire && {awaddr_r[11:2], 2'b00} == arr_pkg::REG_CTRL && wstrb_r[0]) begin
                mode_r   <= wdata_r[arr_pkg::CTRL_MODE_LSB +: 2];
                go_r     <= wdata_r[arr_pkg::CTRL_GO_BIT];
                aux_en_r <= wdata_r[arr_pkg::CTRL_AUX_EN_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            num_cell_r <= arr_pkg::NCELL_RESET;
            bal_sel_r  <= arr_pkg::BAL_SEL_LOOP;
        end else if (wr_fire && {awaddr_r[11:2], 2'b00} == arr_pkg::REG_CFG) begin
            if (wstrb_r[0]) begin
                num_cell_r <= (wdata_r[arr_pkg::CFG_NCELL_LSB +: 5] > arr_pkg::NCELL_MAX) ?
                              arr_pkg::NCELL_MAX : wdata_r[arr_pkg::CFG_NCELL_LSB +: 5];
            end
            if (wstrb_r[1]) begin
                bal_sel_r <= wdata_r[arr_pkg::CFG_BSEL_LSB +: 5];
            end
        end
    end

    // Level shifters follow the cell count captured at active entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_d_r <= 1'b0;
            ls_en_r    <= 16'h0000;
        end else begin
            active_d_r <= dev_active;
            if (dev_active && !active_d_r) begin
                ls_en_r <= 16'(({16'h0000, 1'b1} << num_cell_r) - 17'h00001);
            end else if (!dev_active) begin
                ls_en_r <= 16'h0000;
            end
        end
    end

    // Settle window is only reported; starting early is the host's call
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= 32'h0000_0000;
        end else if ((dev_active && !active_d_r) ||
                     (wr_fire && {awaddr_r[11:2], 2'b00} == arr_pkg::REG_CFG && wstrb_r[0] &&
                      wdata_r[arr_pkg::CFG_NCELL_LSB +: 5] != num_cell_r)) begin
            settle_r <= SETTLE_CYC;
        end else if (settle_r != 32'h0000_0000) begin
            settle_r <= settle_r - 32'h0000_0001;
        end
    end

    // Auxiliary result path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_en_d_r <= 1'b0;
        end else begin
            aux_en_d_r <= aux_en_r;
        end
    end

    assign aux_start  = aux_en_r && !aux_en_d_r;
    assign bal_locked = (bal_sel_r == arr_pkg::BAL_SEL_SHUNT) ||
                        (bal_sel_r != arr_pkg::BAL_SEL_LOOP && (bal_sel_r - 5'h01) <= num_cell_r);
    assign rd_fire    = s_axi_arvalid && s_axi_arready;
    assign rd_dec     = res_decode(s_axi_araddr);

    // Spare slots carry no result; die temperature passes through as a signed code
    genvar k;
    generate
        for (k = 0; k < arr_pkg::N_RESULTS; k = k + 1) begin : g_res
            logic wr_slot;
            logic hi_rd;
            logic lo_rd;
            assign wr_slot = slot_done && (slot == 5'(k)) &&
                             ((5'(k) != arr_pkg::SLOT_BAL) || bal_locked);
            assign hi_rd   = rd_fire && rd_dec.valid && rd_dec.hi && (rd_dec.idx == 4'(k));
            assign lo_rd   = rd_fire && rd_dec.valid && !rd_dec.hi && (rd_dec.idx == 4'(k));

            always_ff @(posedge aclk) begin
                if (!aresetn || aux_start) begin
                    res_hi_r[k] <= arr_pkg::RESULT_DEFAULT[15:8];
                end else if (wr_slot) begin
                    res_hi_r[k] <= aux_conv_data[15:8];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || aux_start) begin
                    res_lo_r[k] <= arr_pkg::RESULT_DEFAULT[7:0];
                end else if (wr_slot && !lo_hold_r[k] && !hi_rd) begin
                    res_lo_r[k] <= aux_conv_data[7:0];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || aux_start) begin
                    lo_hold_r[k] <= 1'b0;
                end else if (hi_rd) begin
                    lo_hold_r[k] <= 1'b1;
                end else if (lo_rd) begin
                    lo_hold_r[k] <= 1'b0;
                end
            end
        end
    endgenerate

    assign filt_valid = mstat.run && mstat.cont && mstat.ready;

    // Read mux
    always_comb begin
        rd_data_c = 32'h0000_0000;
        rd_ok_c   = 1'b1;
        if (rd_dec.valid) begin
            rd_data_c[7:0] = rd_dec.hi ? res_hi_r[rd_dec.idx] : res_lo_r[rd_dec.idx];
        end else begin
            case ({s_axi_araddr[11:2], 2'b00})
                arr_pkg::REG_CTRL: begin
                    rd_data_c[arr_pkg::CTRL_MODE_LSB +: 2]   = mode_r;
                    rd_data_c[arr_pkg::CTRL_AUX_EN_BIT]      = aux_en_r;
                end
                arr_pkg::REG_CFG: begin
                    rd_data_c[arr_pkg::CFG_NCELL_LSB +: 5]   = num_cell_r;
                    rd_data_c[arr_pkg::CFG_BSEL_LSB +: 5]    = bal_sel_r;
                end
                arr_pkg::REG_STAT: begin
                    rd_data_c[0]     = mstat.run;
                    rd_data_c[1]     = mstat.ready;
                    rd_data_c[2]     = filt_valid;
                    rd_data_c[3]     = mstat.frozen;
                    rd_data_c[4]     = aux_en_r;
                    rd_data_c[5]     = (settle_r != 32'h0000_0000);
                    rd_data_c[15:8]  = mstat.rr_cnt;
                    rd_data_c[20:16] = slot;
                end
                arr_pkg::REG_LSHIFT: begin
                    rd_data_c[15:0]  = ls_en_r;
                end
                default: begin
                    rd_ok_c = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= arr_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data_c;
            s_axi_rresp   <= rd_ok_c ? arr_pkg::RESP_OKAY : arr_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Front-end outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_mux_slot      <= 5'h00;
            aux_slot_done     <= 1'b0;
            level_shift_en    <= 16'h0000;
            main_running      <= 1'b0;
            main_cycle_strobe <= 1'b0;
        end else begin
            aux_mux_slot      <= slot;
            aux_slot_done     <= slot_done;
            level_shift_en    <= ls_en_r;
            main_running      <= mstat.run;
            main_cycle_strobe <= mstat.cycle_done;
        end
    end

endmodule
`default_nettype wire

/* sim/arr_top_sva.sv */
// Port checker for the run and round-robin block
`timescale 1ns/1ps
`default_nettype none
module arr_top_sva (
    // Clock, reset, bus
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    // Converter side
    input wire logic        dev_active, aux_slot_done, main_running, main_cycle_strobe,
    input wire logic [4:0]  aux_mux_slot,
    input wire logic [15:0] level_shift_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] gap_r;
    // Zero until a slot end and again after a long pause, so a restarted first slot is not judged
    always_ff @(posedge aclk) begin
        if (!aresetn) gap_r <= 10'h0;
        else if (aux_slot_done) gap_r <= 10'h1;
        else if (gap_r == 10'h3ff) gap_r <= 10'h0;
        else if (gap_r != 10'h0) gap_r <= gap_r + 10'h1;
    end
    property p_slot_max; aux_mux_slot <= 5'h17; endproperty
    a_slot_max: assert property (p_slot_max) else $error("slot out of range");
    property p_slot_next; aux_slot_done |=> aux_mux_slot == (($past(aux_mux_slot) == 5'h17) ? 5'h0
        : $past(aux_mux_slot) + 5'h1); endproperty
    a_slot_next: assert property (p_slot_next) else $error("slot order broken");
    property p_gap; aux_slot_done && gap_r != 10'h0 |-> gap_r == 10'h190; endproperty
    a_gap: assert property (p_gap) else $error("slot length wrong");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_cyc; main_cycle_strobe |=> !main_cycle_strobe [*8]; endproperty
    a_cyc: assert property (p_cyc) else $error("main cycle too short");
    property p_sleep; !dev_active [*3] |-> !main_running && level_shift_en == 16'h0; endproperty
    a_sleep: assert property (p_sleep) else $error("active while asleep");
endmodule
bind arr_top arr_top_sva u_sva (.*);
`default_nettype wire

/* sim/arr_afe_model.sv */
// Auxiliary front-end model giving one value per slot
`timescale 1ns/1ps
`default_nettype none
module arr_afe_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Slot position
    input  wire logic [4:0]  aux_mux_slot,
    input  wire logic        aux_slot_done,
    output logic      [15:0] aux_conv_data
);
    logic [7:0] round_r;
    // Round in low byte so a stale low byte shows
    always_ff @(posedge aclk) begin
        if (!aresetn) round_r <= 8'h40;
        else if (aux_slot_done && aux_mux_slot == 5'h17) round_r <= round_r + 8'h1;
    end
    assign aux_conv_data = {3'h0, aux_mux_slot, round_r};
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the run and round-robin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, dev_active = 0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic        aux_slot_done, main_running, main_cycle_strobe;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [15:0] aux_conv_data, level_shift_en;
    wire logic [4:0]  aux_mux_slot;
    int n_errors = 0;
    int n_compared = 0;
    always #10 aclk = ~aclk;
    arr_top #(.SETTLE_CYC(8)) dut (.*);
    arr_afe_model afe (.*);
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        n_errors++;
        report_and_stop;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        if (k == 50) tmo;
        chk(s_axi_bresp, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] e);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        s_axi_rready <= 0;
        if (k == 50) tmo;
        chk(s_axi_rresp, e);
    endtask
    task automatic wslot;
        int k;
        for (k = 0; k < 12000; k++) begin
            @(posedge aclk);
            if (aux_slot_done && aux_mux_slot == 5'h02) break;
        end
        if (k == 12000) tmo;
    endtask
    task automatic t_burst;
        int n = 0;
        dev_active <= 1;
        cyc(20);
        wr(12'h000, 32'h5, 2'h0);
        repeat (700) begin
            @(posedge aclk);
            n += main_cycle_strobe;
        end
        chk(n, 8);
        chk(main_running, 0);
        rd(12'h008, 2'h0);
        chk(d & 32'hff07, 32'h0802);
    endtask
    task automatic t_cont;
        wr(12'h000, 32'h6, 2'h0);
        cyc(100);
        chk(main_running, 1);
        dev_active <= 0;
        wr(12'h004, 32'h5, 2'h0);
        cyc(5);
        chk(main_running, 0);
        rd(12'h008, 2'h0);
        chk(d & 32'h8, 32'h8);
        dev_active <= 1;
        cyc(10);
        chk(main_running, 1);
        chk(level_shift_en, 32'h1f);
        wr(12'h000, 32'h6, 2'h0);
        cyc(600);
        rd(12'h008, 2'h0);
        chk(d & 32'h4, 32'h4);
        wr(12'h000, 32'h4, 2'h0);
        cyc(5);
        chk(main_running, 0);
    endtask
    task automatic t_aux;
        wr(12'h000, 32'h8, 2'h0);
        rd(12'h050, 2'h0);
        chk(d, 32'h80);
        rd(12'h054, 2'h0);
        chk(d, 32'h0);
        wslot;
        rd(12'h040, 2'h0);
        chk(d, 32'h0);
        rd(12'h048, 2'h0);
        chk(d, 32'h80);
        rd(12'h050, 2'h0);
        chk(d, 32'h2);
        wr(12'h004, 32'h0305, 2'h0);
        wslot;
        rd(12'h054, 2'h0);
        chk(d, 32'h40);
        rd(12'h048, 2'h0);
        chk(d, 32'h1);
        wr(12'h000, 32'h0, 2'h0);
        cyc(1100);
        wr(12'h000, 32'h8, 2'h0);
        rd(12'h040, 2'h0);
        chk(d, 32'h80);
        wr(12'h004, 32'h0105, 2'h0);
    endtask
    initial begin
        cyc(12);
        aresetn <= 1;
        rd(12'h004, 2'h0);
        chk(d & 32'h1f1f, 32'h10);
        rd(12'h100, 2'h2);
        wr(12'h050, 32'h1, 2'h2);
        t_burst;
        t_cont;
        t_aux;
        report_and_stop;
    end
endmodule
`default_nettype wire
